// ==== design/captouch_params.svh ====
// Register offsets, field positions, reset values and counts of the touch sequencer.
`ifndef CAPTOUCH_PARAMS_SVH
`define CAPTOUCH_PARAMS_SVH

// Register byte offsets on the AXI4-Lite bus.
`define CT_OFS_CTRL        8'h00
`define CT_OFS_STATUS      8'h04
`define CT_OFS_POLL_THR    8'h08
`define CT_OFS_TIMING      8'h0C
`define CT_OFS_TOUCH_DATA  8'h10

// Control register fields.
`define CT_CTRL_MODE_LSB   0
`define CT_CTRL_TRIG_BIT   2
`define CT_CTRL_UNUSED_BIT 3
`define CT_CTRL_DIV_LSB    4
`define CT_CTRL_IEN_LSB    8
`define CT_CTRL_SEL_LSB    16
`define CT_CTRL_RESET      32'h0000_0000

// Status register fields.
`define CT_STAT_FLAG_LSB   0
`define CT_STAT_BUSY_BIT   8
`define CT_STAT_STEP_LSB   9
`define CT_STAT_HIGH_LSB   16

// Poll and threshold register fields.
`define CT_PT_THR_LSB      0
`define CT_PT_TOUT_LSB     12
`define CT_PT_POLL_LSB     16
`define CT_PT_LOWER_BIT    24
`define CT_PT_RESET        32'h0000_C000

// Timing register fields.
`define CT_TM_MEAS_LSB     0
`define CT_TM_RST_LSB      8
`define CT_TM_RESET        32'h0000_0101

// Touch data register fields.
`define CT_TD_COUNT_LSB    0
`define CT_TD_XVAL_LSB     16
`define CT_TD_TOUCH_BIT    20
`define CT_TD_TO_BIT       21
`define CT_TD_SEQ_LSB      24

// Event flag positions.
`define CT_EV_YES          0
`define CT_EV_NO           1
`define CT_EV_DONE         2
`define CT_EV_TOUT         3
`define CT_EV_OVR          4

// Log2 of divided clocks per poll field unit.
`define CT_POLL_UNIT_LOG2  12

// AXI responses.
`define CT_RESP_OKAY       2'h0
`define CT_RESP_SLVERR     2'h2

`endif

// ==== design/captouch_pkg.sv ====
// Types shared by the touch sequencer modules.
package captouch_pkg;

  // Measurement step states.
  typedef enum logic [1:0] {
    STEP_RESET    = 2'b00,
    STEP_CHARGE   = 2'b01,
    STEP_TRANSFER = 2'b10,
    STEP_MEASURE  = 2'b11
  } step_e;

  // Polling modes written by software.
  typedef enum logic [1:0] {
    MODE_INACTIVE = 2'b00,
    MODE_NOW      = 2'b01,
    MODE_CONT     = 2'b10,
    MODE_RSVD     = 2'b11
  } poll_mode_e;

  // Sequencer phase around the step machine.
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_WAIT = 2'b01,
    PH_MEAS = 2'b10
  } phase_e;

endpackage

// ==== design/captouch_sync3.sv ====
// Three-flop input synchroniser that accepts a change once the last two stages agree.
`timescale 1ns/10ps
module captouch_sync3 (
  // Clock and reset.
  input  wire logic CLK_SYS,
  input  wire logic RST,
  // Asynchronous level in, filtered level out.
  input  wire logic din,
  output logic      dout
);

  logic meta_q;
  logic s2_q;
  logic s3_q;

  // Only the second stage reads the first; the output moves when stages two and three agree.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      meta_q <= 1'b0;
      s2_q   <= 1'b0;
      s3_q   <= 1'b0;
      dout   <= 1'b0;
    end else begin
      meta_q <= din;
      s2_q   <= meta_q;
      s3_q   <= s2_q;
      if (s2_q == s3_q) begin
        dout <= s3_q;
      end
    end
  end

endmodule

// ==== design/captouch_div.sv ====
// Function clock divider that issues one tick per divided clock period.
`timescale 1ns/10ps
module captouch_div (
  // Clock and reset.
  input  wire logic       CLK_SYS,
  input  wire logic       RST,
  // Ratio minus one, 0 gives divide by 1 and 15 divide by 16.
  input  wire logic [3:0] ratio_m1,
  output logic            tick
);

  logic [3:0] cnt_q;

  // A tick rather than a derived clock keeps the whole block on one clock tree.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      cnt_q <= 4'h0;
      tick  <= 1'b0;
    end else if (cnt_q >= ratio_m1) begin
      cnt_q <= 4'h0;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 4'h1;
      tick  <= 1'b0;
    end
  end

endmodule

// ==== design/captouch_top.sv ====
// Mutual capacitance touch sequencer with AXI4-Lite register access.
// Function
// - Each measurement charges X, transfers to Y, counts iterations until threshold.
// - Step states are 0 reset, 1 charge, 2 transfer, 3 measure.
// - Unselected X pins are held low or high-impedance per the unused pin field.
// - With no measurement running the step machine stays in step 0.
// - Steps 1 to 3 repeat until trigger or iteration time-out.
// - A completed measurement returns to step 0 before any next one.
// - After threshold, Y drains and the next enabled X is measured.
// - Every sensor poll that does not time out yields one touch or no-touch event that can interrupt.
// - Function clock is divided by 1 to 16; all timing uses the divided clock.
// - Touch-below-threshold bit selects whether touch counts lower than no-touch.
// - A single-shot poll gives a baseline count before normal polling.
// - Interrupt enables sit in control; polling starts only once software enables it.
// - At most five X sensor channels exist.
// - Y voltage is sensed from the high side pin or the comparator.
// - A detected touch can request wake-up from low power states.
// - One pin for Y low side, one for Y high side, one per X.
// - Count above threshold is touch unless touch-below-threshold inverts it.
// - Reaching the time-out count flags a time-out and ends that measurement.
// - Between polling rounds wait 4096 times the poll field in divided clocks.
// - In measure step wait the measurement delay before sampling the trigger.
`timescale 1ns/10ps
`include "captouch_params.svh"
module captouch_top #(
  parameter int NUM_X = 5,
  parameter int CNT_W = 12
) (
  // Clock and reset.
  input  wire logic             CLK_SYS,
  input  wire logic             RST,
  // AXI4-Lite write address and data.
  input  wire logic [7:0]       S_AXI_AWADDR,
  input  wire logic             S_AXI_AWVALID,
  output logic                  S_AXI_AWREADY,
  input  wire logic [31:0]      S_AXI_WDATA,
  input  wire logic [3:0]       S_AXI_WSTRB,
  input  wire logic             S_AXI_WVALID,
  output logic                  S_AXI_WREADY,
  // AXI4-Lite write response.
  output logic [1:0]            S_AXI_BRESP,
  output logic                  S_AXI_BVALID,
  input  wire logic             S_AXI_BREADY,
  // AXI4-Lite read.
  input  wire logic [7:0]       S_AXI_ARADDR,
  input  wire logic             S_AXI_ARVALID,
  output logic                  S_AXI_ARREADY,
  output logic [31:0]           S_AXI_RDATA,
  output logic [1:0]            S_AXI_RRESP,
  output logic                  S_AXI_RVALID,
  input  wire logic             S_AXI_RREADY,
  // Sense electrode pins.
  output logic [NUM_X-1:0]      SENSE_X_O,
  output logic [NUM_X-1:0]      SENSE_X_OE,
  // Measurement capacitor pins and comparator.
  input  wire logic             Y_HIGH_SIDE_I,
  output logic                  Y_HIGH_SIDE_O,
  output logic                  Y_HIGH_SIDE_OE,
  output logic                  Y_LOW_SIDE_O,
  output logic                  Y_LOW_SIDE_OE,
  input  wire logic             COMPARATOR_INPUT,
  // Event outputs.
  output logic                  IRQ,
  output logic                  WAKE_REQ
);

  // Register state.
  logic [31:0]      ctrl_q;
  logic [31:0]      poll_thr_q;
  logic [31:0]      timing_q;
  logic [4:0]       flags_q;
  logic [CNT_W-1:0] td_count_q;
  logic [3:0]       td_xval_q;
  logic             td_touch_q;
  logic             td_to_q;
  logic [3:0]       seq_q;
  logic             unread_q;

  // Bus state.
  logic             aw_hold_q;
  logic             w_hold_q;
  logic [7:0]       awaddr_q;
  logic [31:0]      wdata_q;
  logic [3:0]       wstrb_q;

  // Sequencer state.
  captouch_pkg::phase_e phase_q;
  captouch_pkg::step_e  step_q;
  logic [NUM_X-1:0]     mask_q;
  logic [3:0]           xidx_q;
  logic [CNT_W-1:0]     iter_q;
  logic [7:0]           dly_q;
  logic [19:0]          wait_q;

  // Byte-lane merge of a write into a register.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // First selected pin at or above a start index; NUM_X means none.
  function automatic logic [3:0] next_x(input logic [NUM_X-1:0] sel, input logic [3:0] from);
    logic [3:0] r;
    r = 4'(NUM_X);
    for (int i = NUM_X - 1; i >= 0; i--) begin
      if (sel[i] && (4'(i) >= from)) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  // Field views.
  logic [1:0]       mode;
  logic             use_cmp;
  logic             unused_low;
  logic [3:0]       div_m1;
  logic [4:0]       irq_en;
  logic [NUM_X-1:0] sel;
  logic [CNT_W-1:0] thr;
  logic [3:0]       tout;
  logic [7:0]       poll;
  logic             lower;
  logic [7:0]       meas_dly;
  logic [7:0]       rst_dly;
  logic [CNT_W-1:0] tout_m1;
  assign mode       = ctrl_q[`CT_CTRL_MODE_LSB +: 2];
  assign use_cmp    = ctrl_q[`CT_CTRL_TRIG_BIT];
  assign unused_low = ctrl_q[`CT_CTRL_UNUSED_BIT];
  assign div_m1     = ctrl_q[`CT_CTRL_DIV_LSB +: 4];
  assign irq_en     = ctrl_q[`CT_CTRL_IEN_LSB +: 5];
  assign sel        = ctrl_q[`CT_CTRL_SEL_LSB +: NUM_X];
  assign thr        = poll_thr_q[`CT_PT_THR_LSB +: CNT_W];
  assign tout       = poll_thr_q[`CT_PT_TOUT_LSB +: 4];
  assign poll       = poll_thr_q[`CT_PT_POLL_LSB +: 8];
  assign lower      = poll_thr_q[`CT_PT_LOWER_BIT];
  assign meas_dly   = timing_q[`CT_TM_MEAS_LSB +: 8];
  assign rst_dly    = timing_q[`CT_TM_RST_LSB +: 8];
  // Time-out limit is 2 to the power of the field, saturating at the counter width.
  assign tout_m1    = (tout >= 4'(CNT_W)) ? {CNT_W{1'b1}} : CNT_W'((13'h1 << tout) - 13'h1);

  // Divided clock tick and synchronised trigger inputs.
  logic tick;
  logic yh_sync;
  logic cmp_sync;
  captouch_div u_div (
    .CLK_SYS  (CLK_SYS),
    .RST      (RST),
    .ratio_m1 (div_m1),
    .tick     (tick)
  );
  captouch_sync3 u_sync_yh (
    .CLK_SYS (CLK_SYS),
    .RST     (RST),
    .din     (Y_HIGH_SIDE_I),
    .dout    (yh_sync)
  );
  captouch_sync3 u_sync_cmp (
    .CLK_SYS (CLK_SYS),
    .RST     (RST),
    .din     (COMPARATOR_INPUT),
    .dout    (cmp_sync)
  );

  // Measurement end detection and classification.
  logic active;
  logic trig;
  logic meas_end;
  logic timed_out;
  logic is_touch;
  logic round_end;
  logic [3:0] nxt;
  assign active    = (mode == captouch_pkg::MODE_NOW) || (mode == captouch_pkg::MODE_CONT);
  assign trig      = use_cmp ? cmp_sync : yh_sync;
  assign timed_out = !trig && (iter_q == tout_m1);
  assign meas_end  = tick && active && (phase_q == captouch_pkg::PH_MEAS) &&
                     (step_q == captouch_pkg::STEP_MEASURE) && (dly_q >= meas_dly) &&
                     (trig || timed_out);
  assign is_touch  = lower ? (iter_q <= thr) : (iter_q > thr);
  assign nxt       = next_x(sel, xidx_q + 4'h1);
  assign round_end = meas_end && ((mode == captouch_pkg::MODE_NOW) || (nxt == 4'(NUM_X)));

  // Write channel: address and data are held independently, then applied together.
  logic do_write;
  logic wr_ctrl;
  logic wr_stat;
  assign do_write = aw_hold_q && w_hold_q && !S_AXI_BVALID;
  assign wr_ctrl  = do_write && (awaddr_q == `CT_OFS_CTRL);
  assign wr_stat  = do_write && (awaddr_q == `CT_OFS_STATUS);
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `CT_RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_hold_q     <= 1'b1;
        awaddr_q      <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_hold_q     <= 1'b1;
        wdata_q      <= S_AXI_WDATA;
        wstrb_q      <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (do_write) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        // Touch data is read-only, so a write there is refused like an unmapped one.
        S_AXI_BRESP  <= (awaddr_q == `CT_OFS_CTRL || awaddr_q == `CT_OFS_STATUS ||
                         awaddr_q == `CT_OFS_POLL_THR || awaddr_q == `CT_OFS_TIMING) ?
                        `CT_RESP_OKAY : `CT_RESP_SLVERR;
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID  <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
    end
  end

  // Control register; a finished single-shot poll drops the mode back to inactive.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ctrl_q <= `CT_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
    end else if (round_end && (mode == captouch_pkg::MODE_NOW)) begin
      ctrl_q[`CT_CTRL_MODE_LSB +: 2] <= captouch_pkg::MODE_INACTIVE;
    end
  end

  // Parameter registers.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      poll_thr_q <= `CT_PT_RESET;
      timing_q   <= `CT_TM_RESET;
    end else if (do_write && (awaddr_q == `CT_OFS_POLL_THR)) begin
      poll_thr_q <= merge(poll_thr_q, wdata_q, wstrb_q);
    end else if (do_write && (awaddr_q == `CT_OFS_TIMING)) begin
      timing_q <= merge(timing_q, wdata_q, wstrb_q);
    end
  end

  // Event flags: write one to clear, and a new event in the same cycle wins.
  logic [4:0] ev_set;
  logic [4:0] ev_clr;
  logic       td_read;
  assign td_read = S_AXI_ARVALID && S_AXI_ARREADY && (S_AXI_ARADDR == `CT_OFS_TOUCH_DATA);
  always_comb begin
    ev_set              = 5'h00;
    ev_set[`CT_EV_YES]  = meas_end && !timed_out && is_touch;
    ev_set[`CT_EV_NO]   = meas_end && !timed_out && !is_touch;
    ev_set[`CT_EV_DONE] = round_end;
    ev_set[`CT_EV_TOUT] = meas_end && timed_out;
    ev_set[`CT_EV_OVR]  = meas_end && unread_q && !td_read;
    ev_clr              = wr_stat ? (wdata_q[4:0] & {5{wstrb_q[0]}}) : 5'h00;
  end
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      flags_q  <= 5'h00;
      IRQ      <= 1'b0;
      WAKE_REQ <= 1'b0;
    end else begin
      flags_q  <= (flags_q & ~ev_clr) | ev_set;
      // Outputs follow the flags one cycle later, so a cleared flag drops them next edge.
      IRQ      <= |(flags_q & irq_en);
      WAKE_REQ <= flags_q[`CT_EV_YES] && irq_en[`CT_EV_YES];
    end
  end

  // Touch data latched at the end of each measurement.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      td_count_q <= '0;
      td_xval_q  <= 4'h0;
      td_touch_q <= 1'b0;
      td_to_q    <= 1'b0;
      seq_q      <= 4'h0;
      unread_q   <= 1'b0;
    end else begin
      if (meas_end) begin
        td_count_q <= iter_q;
        td_xval_q  <= xidx_q;
        td_touch_q <= !timed_out && is_touch;
        td_to_q    <= timed_out;
        unread_q   <= 1'b1;
      end else if (td_read) begin
        unread_q <= 1'b0;
      end
      if (round_end && (mode == captouch_pkg::MODE_CONT)) begin
        seq_q <= seq_q + 4'h1;
      end
    end
  end

  // Polling sequencer and measurement step machine, advanced on divided clock ticks.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      phase_q <= captouch_pkg::PH_IDLE;
      step_q  <= captouch_pkg::STEP_RESET;
      mask_q  <= '0;
      xidx_q  <= 4'h0;
      iter_q  <= '0;
      dly_q   <= 8'h00;
      wait_q  <= 20'h00000;
    end else if (!active) begin
      // Leaving the polling modes ends any measurement at once.
      phase_q <= captouch_pkg::PH_IDLE;
      step_q  <= captouch_pkg::STEP_RESET;
      mask_q  <= '0;
      dly_q   <= 8'h00;
    end else if (tick) begin
      unique case (phase_q)
        captouch_pkg::PH_IDLE: begin
          dly_q  <= 8'h00;
          wait_q <= 20'h00000;
          if (mode == captouch_pkg::MODE_NOW && sel != '0) begin
            // All selected pins are driven together for the baseline shot.
            phase_q <= captouch_pkg::PH_MEAS;
            mask_q  <= sel;
            xidx_q  <= next_x(sel, 4'h0);
          end else if (mode == captouch_pkg::MODE_CONT) begin
            phase_q <= captouch_pkg::PH_WAIT;
          end
        end
        captouch_pkg::PH_WAIT: begin
          if (wait_q >= {poll, 12'h000}) begin
            wait_q <= 20'h00000;
            if (sel != '0) begin
              phase_q <= captouch_pkg::PH_MEAS;
              xidx_q  <= next_x(sel, 4'h0);
              mask_q  <= NUM_X'(1) << next_x(sel, 4'h0);
              dly_q   <= 8'h00;
            end
          end else begin
            wait_q <= wait_q + 20'h00001;
          end
        end
        captouch_pkg::PH_MEAS: begin
          unique case (step_q)
            captouch_pkg::STEP_RESET: begin
              if (dly_q >= rst_dly) begin
                step_q <= captouch_pkg::STEP_CHARGE;
                iter_q <= '0;
                dly_q  <= 8'h00;
              end else begin
                dly_q <= dly_q + 8'h01;
              end
            end
            captouch_pkg::STEP_CHARGE: begin
              step_q <= captouch_pkg::STEP_TRANSFER;
            end
            captouch_pkg::STEP_TRANSFER: begin
              step_q <= captouch_pkg::STEP_MEASURE;
              dly_q  <= 8'h00;
            end
            captouch_pkg::STEP_MEASURE: begin
              if (dly_q < meas_dly) begin
                dly_q <= dly_q + 8'h01;
              end else if (meas_end) begin
                step_q <= captouch_pkg::STEP_RESET;
                dly_q  <= 8'h00;
                if (round_end) begin
                  phase_q <= (mode == captouch_pkg::MODE_CONT) ?
                             captouch_pkg::PH_WAIT : captouch_pkg::PH_IDLE;
                  mask_q  <= '0;
                  wait_q  <= 20'h00000;
                end else begin
                  xidx_q <= nxt;
                  mask_q <= NUM_X'(1) << nxt;
                end
              end else begin
                iter_q <= iter_q + CNT_W'(1);
                step_q <= captouch_pkg::STEP_CHARGE;
              end
            end
          endcase
        end
        default: begin
          phase_q <= captouch_pkg::PH_IDLE;
        end
      endcase
    end
  end

  // Pin drive per step; inactive selected pins rest low so they do not couple charge.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      SENSE_X_O      <= '0;
      SENSE_X_OE     <= '0;
      Y_HIGH_SIDE_O  <= 1'b0;
      Y_HIGH_SIDE_OE <= 1'b0;
      Y_LOW_SIDE_O   <= 1'b0;
      Y_LOW_SIDE_OE  <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_X; i++) begin
        SENSE_X_O[i] <= mask_q[i] && (step_q == captouch_pkg::STEP_CHARGE);
        if (!sel[i]) begin
          SENSE_X_OE[i] <= unused_low;
        end else if (mask_q[i]) begin
          SENSE_X_OE[i] <= (step_q == captouch_pkg::STEP_RESET) ||
                           (step_q == captouch_pkg::STEP_CHARGE);
        end else begin
          SENSE_X_OE[i] <= 1'b1;
        end
      end
      // High side drained low in step 0, otherwise an input; low side held except in transfer.
      Y_HIGH_SIDE_O  <= 1'b0;
      Y_HIGH_SIDE_OE <= (step_q == captouch_pkg::STEP_RESET);
      Y_LOW_SIDE_O   <= 1'b0;
      Y_LOW_SIDE_OE  <= (step_q != captouch_pkg::STEP_TRANSFER);
    end
  end

  // Read channel; touch data holds the last measurement until the next one ends.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= `CT_RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RRESP   <= `CT_RESP_OKAY;
      S_AXI_RDATA   <= 32'h0000_0000;
      case (S_AXI_ARADDR)
        `CT_OFS_CTRL:     S_AXI_RDATA <= ctrl_q;
        `CT_OFS_POLL_THR: S_AXI_RDATA <= poll_thr_q;
        `CT_OFS_TIMING:   S_AXI_RDATA <= timing_q;
        `CT_OFS_STATUS: begin
          S_AXI_RDATA[`CT_STAT_FLAG_LSB +: 5] <= flags_q;
          S_AXI_RDATA[`CT_STAT_BUSY_BIT]      <= (phase_q == captouch_pkg::PH_MEAS);
          S_AXI_RDATA[`CT_STAT_STEP_LSB +: 2] <= step_q;
          S_AXI_RDATA[`CT_STAT_HIGH_LSB +: 4] <= 4'(NUM_X - 1);
        end
        `CT_OFS_TOUCH_DATA: begin
          S_AXI_RDATA[`CT_TD_COUNT_LSB +: CNT_W] <= td_count_q;
          S_AXI_RDATA[`CT_TD_XVAL_LSB +: 4]      <= td_xval_q;
          S_AXI_RDATA[`CT_TD_TOUCH_BIT]          <= td_touch_q;
          S_AXI_RDATA[`CT_TD_TO_BIT]             <= td_to_q;
          S_AXI_RDATA[`CT_TD_SEQ_LSB +: 4]       <= seq_q;
        end
        default: S_AXI_RRESP <= `CT_RESP_SLVERR;
      endcase
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID  <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

endmodule

// ==== tb/captouch_assertions.sv ====
// Bus and pin checks for the touch sequencer.
`timescale 1ns/10ps
module captouch_assertions #(parameter int NUM_X = 5) (
  // Clock, reset and bus handshakes.
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Pins and events.
  input wire logic [NUM_X-1:0] SENSE_X_O,
  input wire logic [NUM_X-1:0] SENSE_X_OE,
  input wire logic Y_HIGH_SIDE_O,
  input wire logic Y_HIGH_SIDE_OE,
  input wire logic Y_LOW_SIDE_OE,
  input wire logic IRQ,
  input wire logic WAKE_REQ
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  // Answers hold until taken; a lost answer would hang software for good.
  property p_b_hold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID; endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
  property p_b_code; S_AXI_BVALID |-> S_AXI_BRESP inside {2'h0, 2'h2}; endproperty
  a_b_code: assert property (p_b_code) else $error("bad bresp");
  property p_r_hold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID; endproperty
  a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
  property p_r_lat; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
  a_r_lat: assert property (p_r_lat) else $error("late read");
  property p_r_busy; S_AXI_RVALID |-> !S_AXI_ARREADY; endproperty
  a_r_busy: assert property (p_r_busy) else $error("read overlap");
  // A charging X must see a grounded low side, and a drain only pulls low.
  property p_drain; Y_HIGH_SIDE_OE |-> !Y_HIGH_SIDE_O; endproperty
  a_drain: assert property (p_drain) else $error("drain high");
  property p_charge; |(SENSE_X_O & SENSE_X_OE) |-> Y_LOW_SIDE_OE; endproperty
  a_charge: assert property (p_charge) else $error("charge float");
  property p_wake; WAKE_REQ |-> IRQ; endproperty
  a_wake: assert property (p_wake) else $error("wake alone");
endmodule
bind captouch_top captouch_assertions #(.NUM_X(NUM_X)) chk_u (.*);

// ==== tb/captouch_electrodes.sv ====
// Behavioural electrode and measurement capacitor network.
`timescale 1ns/10ps
module captouch_electrodes (
  // Board side of the pins.
  input wire logic clk,
  input wire logic [4:0] x_o,
  input wire logic [4:0] x_oe,
  input wire logic yh_oe,
  input wire logic [7:0] trip,
  output logic yh,
  output logic cmp
);
  logic [7:0] chg_q = 8'h00;
  logic hi_q = 1'h0;
  // Each charge pulse moves one packet onto Y; a driven high side drains it.
  always_ff @(posedge clk) begin
    hi_q <= |(x_o & x_oe);
    if (yh_oe) chg_q <= 8'h00;
    else if (|(x_o & x_oe) && !hi_q) chg_q <= chg_q + 8'h01;
  end
  // Both sense paths trip at the same charge, so either method gives one count.
  assign yh = chg_q >= trip;
  assign cmp = yh;
endmodule

// ==== tb/mutual_cap_touch_sequencer_test.sv ====
// Self-checking bench for the touch sequencer.
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module mutual_cap_touch_sequencer_test;
  logic CLK_SYS = 1'h0;
  logic RST = 1'h1;
  logic [7:0] S_AXI_AWADDR = '0, S_AXI_ARADDR = '0, trip = '0;
  logic [31:0] S_AXI_WDATA = '0, S_AXI_RDATA, rd_q;
  logic [3:0] S_AXI_WSTRB = 4'hF;
  logic S_AXI_AWVALID = '0, S_AXI_WVALID = '0, S_AXI_BREADY = '0;
  logic S_AXI_ARVALID = '0, S_AXI_RREADY = '0, S_AXI_AWREADY, S_AXI_WREADY;
  logic S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, IRQ, WAKE_REQ, yh;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic [4:0] SENSE_X_O, SENSE_X_OE;
  logic Y_HIGH_SIDE_O, Y_HIGH_SIDE_OE, Y_LOW_SIDE_O, Y_LOW_SIDE_OE, COMPARATOR_INPUT;
  wire logic Y_HIGH_SIDE_I = Y_HIGH_SIDE_OE ? Y_HIGH_SIDE_O : yh;
  int err_count = 0, compares = 0, cyc = 0;
  // Reset table, then poll cases: trip, threshold word, control word, flags, data.
  logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14};
  logic [31:0] rv [5] = '{32'h0, 32'h0004_0000, 32'h0000_C000, 32'h0000_0101, 32'h0};
  // The last case polls X0 and X2 continuously, so the second end finds data unread.
  logic [7:0] tp [5] = '{8'h0A, 8'h03, 8'h03, 8'hC8, 8'h03};
  logic [31:0] pt [5] = '{32'h0000_6005, 32'h0000_6005, 32'h0100_6005, 32'h0000_3005,
    32'h0000_6005};
  logic [31:0] ct [5] = '{32'h0001_1F39, 32'h0001_1F31, 32'h0001_1F3D, 32'h0001_1F39,
    32'h0005_1F3A};
  logic [4:0] fl [5] = '{5'h05, 5'h06, 5'h05, 5'h0C, 5'h16};
  logic [31:0] td [5] = '{32'h0010_0009, 32'h2, 32'h0010_0002, 32'h0020_0007,
    32'h0102_0002};
  always #5 CLK_SYS = ~CLK_SYS;
  captouch_top dut_u (.*);
  captouch_electrodes net_u (.clk(CLK_SYS), .x_o(SENSE_X_O), .x_oe(SENSE_X_OE),
    .yh_oe(Y_HIGH_SIDE_OE), .trip(trip), .yh(yh), .cmp(COMPARATOR_INPUT));
  // Verdict in one place, also reached when a wait hangs.
  task automatic close_out;
    if (err_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge CLK_SYS) if (++cyc > 20000) begin err_count++; close_out; end
  // Bus write: both channels offered together, each dropped once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'h1;
    S_AXI_WVALID <= 1'h1;
    S_AXI_BREADY <= 1'h1;
    do begin
      @(posedge CLK_SYS);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'h0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'h0;
    end while (!S_AXI_BVALID);
    `CHK("bresp", er, S_AXI_BRESP)
    S_AXI_BREADY <= 1'h0;
    @(posedge CLK_SYS);
  endtask
  // Bus read; the extra edge keeps ready changes one per time step.
  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'h1;
    S_AXI_RREADY <= 1'h1;
    do begin
      @(posedge CLK_SYS);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'h0;
    end while (!S_AXI_RVALID);
    d = S_AXI_RDATA;
    `CHK("rresp", er, S_AXI_RRESP)
    S_AXI_RREADY <= 1'h0;
    @(posedge CLK_SYS);
  endtask
  initial begin
    repeat (6) @(posedge CLK_SYS);
    RST <= 1'h0;
    @(posedge CLK_SYS);
    foreach (ra[i]) begin
      rd(ra[i], rd_q, (i == 4) ? 2'h2 : 2'h0);
      `CHK("reset value", rv[i], rd_q)
    end
    wr(8'h10, 32'hFFFF_FFFF, 2'h2);
    foreach (tp[i]) begin
      trip <= tp[i];
      wr(8'h04, 32'h0000_001F, 2'h0);
      wr(8'h08, pt[i], 2'h0);
      wr(8'h00, ct[i], 2'h0);
      rd_q = '0;
      while (!rd_q[2]) rd(8'h04, rd_q, 2'h0);
      `CHK("flags", fl[i], rd_q[4:0])
      `CHK("step", 2'h0, rd_q[10:9])
      `CHK("irq", 1'h1, IRQ)
      `CHK("wake", fl[i][0], WAKE_REQ)
      rd(8'h10, rd_q, 2'h0);
      `CHK("touch data", td[i], rd_q)
      `CHK("unused x", {4{ct[i][3]}}, SENSE_X_OE[4:1])
    end
    wr(8'h00, 32'h0, 2'h0);
    `CHK("irq masked", 1'h0, IRQ)
    close_out;
  end
endmodule
